/* logic/plse_pkg.sv */
// Register map, field layout and timing constants of the PHY status bank
package plse_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h11;
  localparam logic [5:0] IDX_EXT_CTRL = 6'h14;
  localparam logic [5:0] IDX_ERR_TALLY = 6'h15;
  localparam logic [5:0] IDX_WATCH_CTRL = 6'h18;
  localparam int ADDR_W = 8;
  localparam int WORD_LSB = 2;
  // Field layout of the status register
  localparam int SPD_W = 2;
  localparam int CLEN_W = 3;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] STAT_GAP = 2'h0;
  // Cable length codes and their upper bounds in metres
  localparam logic [2:0] CLEN_LT50 = 3'h0;
  localparam logic [2:0] CLEN_50_80 = 3'h1;
  localparam logic [2:0] CLEN_80_110 = 3'h2;
  localparam logic [2:0] CLEN_110_140 = 3'h3;
  localparam logic [2:0] CLEN_GT140 = 3'h4;
  localparam logic [7:0] LEN_50M = 8'h32;
  localparam logic [7:0] LEN_80M = 8'h50;
  localparam logic [7:0] LEN_110M = 8'h6e;
  localparam logic [7:0] LEN_140M = 8'h8c;
  // Extended control: bit 15 read-only, bits 14:0 kept by software
  localparam int EXT_W = 15;
  localparam logic [14:0] EXT_CTRL_RST = 15'h0c60;
  localparam logic WATCH_EN_RST = 1'b1;
  // Error tally
  localparam int TALLY_W = 16;
  localparam logic [15:0] TALLY_MAX = 16'hffff;
  localparam logic [15:0] TALLY_ONE = 16'h0001;
  localparam logic [15:0] TALLY_ZERO = 16'h0000;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Idle loss timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_LOSS_NS = 1000000;
  localparam int IDLE_LOSS_CYC = IDLE_LOSS_NS / CLK_PERIOD_NS;
  localparam int IDLE_CNT_W = 17;
endpackage

/* logic/plse_idle_watch.sv */
// Idle-pattern loss timer: flags lock lost after a quiet interval
`timescale 1ns/1ps
module plse_idle_watch #(
  parameter int LOSS_CYC = plse_pkg::IDLE_LOSS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic idle_seen,
  output logic lost_q
);
  localparam logic [plse_pkg::IDLE_CNT_W-1:0] LIMIT =
    plse_pkg::IDLE_CNT_W'(LOSS_CYC - 1);
  localparam logic [plse_pkg::IDLE_CNT_W-1:0] ZERO = '0;
  localparam logic [plse_pkg::IDLE_CNT_W-1:0] ONE = plse_pkg::IDLE_CNT_W'(1);

  logic [plse_pkg::IDLE_CNT_W-1:0] quiet_q;

  // Cycles since the last idle pattern; holds at the limit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable || idle_seen)
      quiet_q <= ZERO;
    else if (quiet_q != LIMIT)
      quiet_q <= quiet_q + ONE;
  end

  // Lost once the full interval passes; fresh idles restore lock
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable || idle_seen)
      lost_q <= 1'b0;
    else if (quiet_q == LIMIT)
      lost_q <= 1'b1;
  end
endmodule // plse_idle_watch

/* logic/plse_regs.sv */
// PHY link status, extended control and receive error registers
//
// Overview of operation
// - Speed field reads 10 gigabit, 01 hundred, 00 ten megabit.
// - Duplex bit reads one for full duplex, zero for half.
// - Speed, duplex, crossover, pause fields meaningful only once resolved.
// - Resolved bit set when negotiation finished or disabled, else zero.
// - Page-arrival bit latches high until status register read.
// - Link bit reads one while link up, zero while down.
// - Cable length coded 000 to 100 across five distance bands.
// - Crossover bit one when pairs A/B and C/D swapped.
// - Two bits mirror attached MAC transmit and receive pause capability.
// - Polarity bit set when any pair has wires reversed.
// - Jabber bit reads one while jabber detected.
// - No idles for 1 ms drops link and sets lock-lost bit.
// - Sixteen-bit counter counts each gigabit receive error.
// - Error counter saturates at all ones, never wraps.
// - Latching self-clearing values clear on each read of register.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module plse_regs #(
  parameter int IDLE_LOSS_CYC = plse_pkg::IDLE_LOSS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [plse_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [plse_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Line-side status from the transceiver core
  input wire logic [1:0] line_speed,
  input wire logic line_full_duplex,
  input wire logic an_enabled,
  input wire logic an_complete,
  input wire logic page_rx,
  input wire logic line_link_ok,
  input wire logic [7:0] cable_len_m,
  input wire logic pair_swap_flag,
  input wire logic host_tx_flow_halt_cap,
  input wire logic host_rx_flow_halt_cap,
  input wire logic [3:0] pair_pol_rev,
  input wire logic jabber,
  input wire logic idle_seen,
  input wire logic rx_error,
  // Results
  output logic link_up,
  output logic [plse_pkg::EXT_W-1:0] ext_ctrl
);
  localparam int RAW_W = 25;

  logic [RAW_W-1:0] meta_q;
  logic [RAW_W-1:0] sync_q;
  logic [1:0] s_speed;
  logic s_duplex;
  logic s_an_en;
  logic s_an_done;
  logic s_page;
  logic s_link;
  logic [7:0] s_len;
  logic s_xover;
  logic s_txp;
  logic s_rxp;
  logic [3:0] s_pol;
  logic s_jab;
  logic s_idle;
  logic s_err;
  logic page_d_q;
  logic err_d_q;
  logic page_ev;
  logic err_ev;
  logic page_q;
  logic lock_lost;
  logic watch_en_q;
  logic [plse_pkg::TALLY_W-1:0] tally_q;
  logic [2:0] clen_code;
  logic resolved;
  logic [15:0] status_word;
  // Write channel state
  logic aw_held_q;
  logic w_held_q;
  logic [5:0] wr_idx_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic b_hs;
  // Read channel state
  logic ar_hs;
  logic r_hs;
  logic [5:0] rd_idx;
  logic rd_status;
  logic rd_tally;
  logic [31:0] rd_word;
  logic rd_hit;

  // Two-flop synchroniser for every line input
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= {line_speed, line_full_duplex, an_enabled, an_complete, page_rx,
                 line_link_ok, cable_len_m, pair_swap_flag, host_tx_flow_halt_cap,
                 host_rx_flow_halt_cap, pair_pol_rev, jabber, idle_seen, rx_error};
      sync_q <= meta_q;
    end
  end

  assign {s_speed, s_duplex, s_an_en, s_an_done, s_page, s_link, s_len, s_xover,
          s_txp, s_rxp, s_pol, s_jab, s_idle, s_err} = sync_q;

  // Edge detect on the synchronised event levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      page_d_q <= 1'b0;
      err_d_q <= 1'b0;
    end
    else
    begin
      page_d_q <= s_page;
      err_d_q <= s_err;
    end
  end

  assign page_ev = s_page & ~page_d_q;
  assign err_ev = s_err & ~err_d_q;

  // Handshake strobes
  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign do_wr = aw_held_q & w_held_q & ~bvalid;
  assign b_hs = bvalid & bready;
  assign ar_hs = arvalid & arready;
  assign r_hs = rvalid & rready;
  assign rd_idx = araddr[plse_pkg::WORD_LSB +: 6];
  assign rd_status = ar_hs && (rd_idx == plse_pkg::IDX_STATUS);
  assign rd_tally = ar_hs && (rd_idx == plse_pkg::IDX_ERR_TALLY);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      page_q <= 1'b0;
    else if (page_ev)
      page_q <= 1'b1;
    else if (rd_status)
      page_q <= 1'b0;
  end

  plse_idle_watch #(
    .LOSS_CYC(IDLE_LOSS_CYC)
  ) u_idle_watch (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(watch_en_q),
    .idle_seen(s_idle),
    .lost_q(lock_lost)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      link_up <= 1'b0;
    else
      link_up <= s_link & ~lock_lost;
  end

  // clear on read; a same-cycle error survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tally_q <= plse_pkg::TALLY_ZERO;
    else if (rd_tally)
      tally_q <= err_ev ? plse_pkg::TALLY_ONE : plse_pkg::TALLY_ZERO;
    else if (err_ev && tally_q != plse_pkg::TALLY_MAX)
      tally_q <= tally_q + plse_pkg::TALLY_ONE;
  end

  always_comb
  begin
    if (s_len < plse_pkg::LEN_50M)
      clen_code = plse_pkg::CLEN_LT50;
    else if (s_len < plse_pkg::LEN_80M)
      clen_code = plse_pkg::CLEN_50_80;
    else if (s_len < plse_pkg::LEN_110M)
      clen_code = plse_pkg::CLEN_80_110;
    else if (s_len < plse_pkg::LEN_140M)
      clen_code = plse_pkg::CLEN_110_140;
    else
      clen_code = plse_pkg::CLEN_GT140;
  end

  // resolved when done or negotiation off
  assign resolved = s_an_done | ~s_an_en;

  // fields shown raw; software checks the resolved bit
  assign status_word = {s_speed, s_duplex, page_q, resolved, link_up, clen_code,
                        s_xover, plse_pkg::STAT_GAP, s_txp, s_rxp, |s_pol, s_jab};

  // Write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      wr_idx_q <= '0;
    end
    else if (aw_hs)
    begin
      aw_held_q <= 1'b1;
      wr_idx_q <= awaddr[plse_pkg::WORD_LSB +: 6];
    end
    else if (do_wr)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end
    else if (w_hs)
    begin
      w_held_q <= 1'b1;
      wr_data_q <= wdata;
      wr_strb_q <= wstrb;
    end
    else if (do_wr)
      w_held_q <= 1'b0;
  end

  // Ready drops on capture and returns once the response is gone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
    end
    else
    begin
      awready <= ~(aw_hs | aw_held_q | bvalid);
      wready <= ~(w_hs | w_held_q | bvalid);
    end
  end

  // unused bits stored exactly as written
  // reserved bit kept writable so it reads back
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_ctrl <= plse_pkg::EXT_CTRL_RST;
    else if (do_wr && wr_idx_q == plse_pkg::IDX_EXT_CTRL)
    begin
      if (wr_strb_q[0])
        ext_ctrl[7:0] <= wr_data_q[7:0];
      if (wr_strb_q[1])
        ext_ctrl[14:8] <= wr_data_q[14:8];
    end
  end

  // Idle watch enable; off leaves the link to the raw level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      watch_en_q <= plse_pkg::WATCH_EN_RST;
    else if (do_wr && wr_idx_q == plse_pkg::IDX_WATCH_CTRL && wr_strb_q[0])
      watch_en_q <= wr_data_q[0];
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= plse_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid <= 1'b1;
      bresp <= (wr_idx_q == plse_pkg::IDX_EXT_CTRL ||
                wr_idx_q == plse_pkg::IDX_WATCH_CTRL) ?
               plse_pkg::RESP_OKAY : plse_pkg::RESP_SLVERR;
    end
    else if (b_hs)
      bvalid <= 1'b0;
  end

  // Read mux; writes to read-only or unmapped indices answer SLVERR
  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (rd_idx)
      plse_pkg::IDX_STATUS: rd_word[15:0] = status_word;
      plse_pkg::IDX_EXT_CTRL: rd_word[15:0] = {lock_lost, ext_ctrl};
      plse_pkg::IDX_ERR_TALLY: rd_word[15:0] = tally_q;
      plse_pkg::IDX_WATCH_CTRL: rd_word[0] = watch_en_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data registered on the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata <= '0;
      rresp <= plse_pkg::RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rdata <= rd_word;
      rresp <= rd_hit ? plse_pkg::RESP_OKAY : plse_pkg::RESP_SLVERR;
    end
  end

  // One read in flight; ready returns after the data is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
    end
    else if (ar_hs)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
    end
    else if (r_hs)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end
endmodule // plse_regs

/* tb/plse_regs_monitor.sv */
// Bus handshake and link-path checker for the PHY status register bank
`timescale 1ns/1ps
module plse_regs_monitor #(
  parameter int LOSS = plse_pkg::IDLE_LOSS_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic line_link_ok,
  input wire logic idle_seen,
  input wire logic link_up,
  input wire logic [plse_pkg::EXT_W-1:0] ext_ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int quiet_q;
  // Quiet time on the line; margin later covers the synchroniser
  always_ff @(posedge aclk)
  begin
    quiet_q <= (!aresetn || idle_seen) ? 0 : quiet_q + 1;
  end
  sequence s_ar;
    arvalid && arready;
  endsequence
  sequence s_r;
    rvalid && rready;
  endsequence
  a_read_answer: assert property (s_ar |=> rvalid) else $error("read not answered");
  a_read_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000) else $error("upper set");
  a_read_gap: assert property (s_r |=> !rvalid && !arready) else $error("read gap missing");
  a_read_free: assert property ($fell(rvalid) |=> arready) else $error("read stuck");
  a_write_block: assert property (bvalid |-> !awready && !wready) else $error("write early");
  a_write_free: assert property ($fell(bvalid) |=> awready && wready) else $error("write stuck");
  a_link_down: assert property ((!line_link_ok) [*4] |-> !link_up)
    else $error("link up while pin low");
  a_lock_drop: assert property (quiet_q > LOSS + 6 |-> !link_up)
    else $error("link up without idles");
  a_ctrl_reset: assert property ($rose(aresetn) |-> ext_ctrl == plse_pkg::EXT_CTRL_RST)
    else $error("control reset value");
endmodule // plse_regs_monitor
bind plse_regs plse_regs_monitor #(.LOSS(IDLE_LOSS_CYC)) i_plse_regs_monitor (.*);

/* tb/plse_host.sv */
// Host management model: AXI4-Lite master of the PHY register bank
`timescale 1ns/1ps
module plse_host (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  output logic rready
);
  logic [31:0] last_q;
  // Bus idle from time zero
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask
  // Read data captured at the edge that shows it
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    last_q = rdata;
    rready <= 1'b0;
  endtask
  task automatic keep_ctrl();
    rd({plse_pkg::IDX_EXT_CTRL, 2'b00});
    wr({plse_pkg::IDX_EXT_CTRL, 2'b00}, last_q);
  endtask
endmodule // plse_host

/* tb/plse_regs_tb_top.sv */
// Self-checking bench for the PHY status, control and error registers
`timescale 1ns/1ps
module plse_regs_tb_top;
  localparam logic [7:0] A_ST = {plse_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_EC = {plse_pkg::IDX_EXT_CTRL, 2'b00};
  localparam logic [7:0] A_ET = {plse_pkg::IDX_ERR_TALLY, 2'b00};
  localparam logic [7:0] A_WC = {plse_pkg::IDX_WATCH_CTRL, 2'b00};
  localparam logic [1:0] OK = plse_pkg::RESP_OKAY;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, s;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, link_up;
  logic [14:0] ext_ctrl;
  logic [1:0] line_speed = 2'h0;
  logic line_full_duplex = 1'b0, an_enabled = 1'b0, an_complete = 1'b0;
  logic page_rx = 1'b0, line_link_ok = 1'b0, pair_swap_flag = 1'b0;
  logic host_tx_flow_halt_cap = 1'b0, host_rx_flow_halt_cap = 1'b0;
  logic jabber = 1'b0, idle_seen = 1'b1, rx_error = 1'b0;
  logic [7:0] cable_len_m = 8'h00;
  logic [3:0] pair_pol_rev = 4'h0;
  logic [11:0] r;
  logic [15:0] k;
  logic [7:0] lens [9] = '{8'h31, 8'h32, 8'h4f, 8'h50, 8'h6d, 8'h6e, 8'h8b, 8'h8c, 8'hff};
  logic [33:0] exp_q [$];
  logic [33:0] e;
  int mismatches = 0;
  int n_tests = 0;
  always #5 aclk = ~aclk;
  plse_regs #(.IDLE_LOSS_CYC(20)) i_plse_regs (.*);
  plse_host i_plse_host (.*);
  function automatic logic [2:0] band(input logic [7:0] m);
    return (m < 8'h32) ? 3'h0 : (m < 8'h50) ? 3'h1 : (m < 8'h6e) ? 3'h2 : (m < 8'h8c) ? 3'h3 : 3'h4;
  endfunction
  task automatic ex(input logic [1:0] rs, input logic [31:0] d);
    exp_q.push_back({rs, d});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Each answer against the oldest note; writes compare the code only
  always @(posedge aclk)
  begin
    if ((rvalid && rready) || (bvalid && bready))
    begin
      e = exp_q.pop_front();
      n_tests++;
      if (rvalid ? ({rresp, rdata} !== e) : (bresp !== e[33:32]))
      begin
        mismatches++;
        $display("Error at %0t: got %h %h exp %h", $time, rresp, rdata, e);
      end
    end
  end
  // Run is a few hundred cycles
  initial
  begin
    #200000;
    mismatches++;
    stop_test();
  end
  initial
  begin
    w = $urandom(94);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ex(OK, 32'h0c60);
    i_plse_host.rd(A_EC);
    // Every length band, random line state, page on odd passes
    for (int i = 0; i < 9; i++)
    begin
      r = 12'($urandom);
      s = 2'($urandom_range(2));
      @(posedge aclk);
      {line_full_duplex, an_enabled, an_complete, line_link_ok, pair_swap_flag} <= r[11:7];
      {host_tx_flow_halt_cap, host_rx_flow_halt_cap, pair_pol_rev, jabber} <= r[6:0];
      line_speed <= s;
      cable_len_m <= lens[i];
      page_rx <= i[0];
      @(posedge aclk);
      page_rx <= 1'b0;
      repeat (5) @(posedge aclk);
      ex(OK, {16'h0, s, r[11], i[0], r[9] | ~r[10], r[8], band(lens[i]), r[7], 2'b00,
        r[6], r[5], |r[4:1], r[0]});
      i_plse_host.rd(A_ST);
    end
    $display("status test done");
    k = 16'($urandom_range(9, 1));
    repeat (k)
    begin
      @(posedge aclk);
      rx_error <= 1'b1;
      @(posedge aclk);
      rx_error <= 1'b0;
    end
    repeat (5) @(posedge aclk);
    ex(OK, {16'h0, k});
    i_plse_host.rd(A_ET);
    ex(plse_pkg::RESP_SLVERR, 32'h0);
    i_plse_host.wr(A_ET, 32'hffff);
    ex(OK, 32'h0);
    i_plse_host.rd(A_ET);
    $display("tally test done");
    // Upper and read-only bits random; kept bits written as they stand
    w = {17'($urandom), plse_pkg::EXT_CTRL_RST};
    ex(OK, 32'h0);
    i_plse_host.wr(A_EC, w);
    w = {17'h0, w[14:0]};
    ex(OK, w);
    ex(OK, w);
    ex(OK, 32'h0);
    i_plse_host.rd(A_EC);
    i_plse_host.keep_ctrl();
    // Watch off: a quiet spell longer than the 20-cycle loss interval must not flag lock lost
    ex(OK, 32'h1);
    i_plse_host.rd(A_WC);
    ex(OK, 32'h0);
    i_plse_host.wr(A_WC, 32'h0);
    idle_seen <= 1'b0;
    repeat (22) @(posedge aclk);
    ex(OK, w);
    i_plse_host.rd(A_EC);
    idle_seen <= 1'b1;
    ex(OK, 32'h0);
    i_plse_host.wr(A_WC, 32'h1);
    idle_seen <= 1'b0;
    repeat (40) @(posedge aclk);
    ex(OK, w | 32'h8000);
    i_plse_host.rd(A_EC);
    idle_seen <= 1'b1;
    repeat (6) @(posedge aclk);
    ex(OK, w);
    i_plse_host.rd(A_EC);
    $display("control test done");
    ex(plse_pkg::RESP_SLVERR, 32'h0);
    i_plse_host.rd(8'h00);
    ex(plse_pkg::RESP_SLVERR, 32'h0);
    i_plse_host.wr(8'h04, 32'hffff);
    $display("map test done");
    repeat (3) @(posedge aclk);
    stop_test();
  end
endmodule // plse_regs_tb_top
